/* ppc_pkg.sv */
// Purpose: Shared constants and carriers for the port P pin control block
// Assumes: APB4 slave with 32-bit data and 8-bit registers in the low lane
// Notes: Register indices are word indices; byte address is index times four
package ppc_pkg;

  localparam int PPC_WIDTH = 8;
  localparam int PPC_AW = 12;

  // Register word indices
  localparam logic [9:0] PPC_IDX_DATA = 10'h258;
  localparam logic [9:0] PPC_IDX_INPUT = 10'h259;
  localparam logic [9:0] PPC_IDX_DIR = 10'h25A;
  localparam logic [9:0] PPC_IDX_DRIVE = 10'h25B;
  localparam logic [9:0] PPC_IDX_PULL = 10'h25C;
  localparam logic [9:0] PPC_IDX_POL = 10'h25D;
  localparam logic [9:0] PPC_IDX_IRQ_EN = 10'h25E;
  localparam logic [9:0] PPC_IDX_IRQ_STAT = 10'h25F;
  localparam logic [9:0] PPC_IDX_IRQ_CLR = 10'h260;

  // Reset values
  localparam logic [7:0] PPC_RST_DATA = 8'h00;
  localparam logic [7:0] PPC_RST_DIR = 8'h00;
  localparam logic [7:0] PPC_RST_DRIVE = 8'h00;
  localparam logic [7:0] PPC_RST_PULL = 8'h00;
  localparam logic [7:0] PPC_RST_POL = 8'h00;
  localparam logic [7:0] PPC_RST_IRQ_EN = 8'h00;
  localparam logic [7:0] PPC_RST_FLAG = 8'h00;

  // Pin field positions and peripheral routing masks
  localparam int PPC_PIN_SHUTDOWN = 7;
  localparam logic [7:0] PPC_TIMER_MASK = 8'h07;
  localparam logic [7:0] PPC_SCI_MASK = 8'h05;

  // Requests from the sharing peripherals, one bit per pin except pwm_shutdown_en
  typedef struct packed {
    logic [7:0] pwm_en;
    logic [7:0] pwm_out;
    logic pwm_shutdown_en;
    logic [7:0] timer_oc_en;
    logic [7:0] timer_out;
    logic [7:0] sci_en;
    logic [7:0] sci_oe;
    logic [7:0] sci_out;
  } ppc_periph_s;

  // Pad controls, one bit per pin
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] reduced;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } ppc_pad_s;

endpackage

/* ppc_top.sv */
// Purpose: Direction, drive, pull and pin interrupt control of port P
// Assumes: Single clock; pin inputs arrive asynchronously
// Notes: APB slave answers with zero wait states after its setup cycle
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps

module ppc_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ppc_pkg::PPC_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Peripheral requests
  input wire ppc_pkg::ppc_periph_s periph_i,
  // Pins
  input wire logic [7:0] pin_in_i,
  output ppc_pkg::ppc_pad_s pad_o,
  output logic [7:0] pin_sync_o,
  // Interrupt
  output logic irq_o
);
  import ppc_pkg::*;

  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] drive_q;
  logic [7:0] pull_q;
  logic [7:0] pol_q;
  logic [7:0] irq_en_q;
  logic [7:0] flag_q;
  logic [7:0] flag_d;
  logic [7:0] meta_q;
  logic [7:0] sync_q;
  logic [7:0] prev_q;
  logic [7:0] edge_hit;
  logic [7:0] eff_oe;
  logic [7:0] eff_out;
  logic [7:0] clr_req;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [9:0] widx;
  logic wr_en;
  logic setup;
  logic [7:0] rd_byte;
  logic rd_hit;
  ppc_pad_s pad_q;
  ppc_pad_s pad_d;

  // Matches a register index against the word address on the bus
  function automatic logic idx_is(input logic [9:0] a,
                                  input logic [9:0] idx);
    idx_is = (a == idx);
  endfunction

  // Word address; the index takes all address bits above the two low ones, which are ignored
  assign widx = paddr_i[11:2];
  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pwrite_i & pstrb_i[0];

  // Registered read path, captured in the setup cycle
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (1'b1)
      idx_is(widx, PPC_IDX_DATA): begin
        rd_byte = (data_q & dir_q) | (sync_q & ~dir_q);
      end
      idx_is(widx, PPC_IDX_INPUT): begin
        rd_byte = sync_q;
      end
      idx_is(widx, PPC_IDX_DIR): begin
        rd_byte = dir_q;
      end
      idx_is(widx, PPC_IDX_DRIVE): begin
        rd_byte = drive_q;
      end
      idx_is(widx, PPC_IDX_PULL): begin
        rd_byte = pull_q;
      end
      idx_is(widx, PPC_IDX_POL): begin
        rd_byte = pol_q;
      end
      idx_is(widx, PPC_IDX_IRQ_EN): begin
        rd_byte = irq_en_q;
      end
      idx_is(widx, PPC_IDX_IRQ_STAT): begin
        rd_byte = flag_q;
      end
      idx_is(widx, PPC_IDX_IRQ_CLR): begin
        rd_byte = 8'h00;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= {24'h00_0000, rd_byte};
      pslverr_q <= ~rd_hit;
    end
  end

  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q;
  // Zero wait states keep the slave simple; setup already did the decode
  assign pready_o = 1'b1;

  // Software registers; a write to an unmapped word is dropped
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      data_q <= PPC_RST_DATA;
    end else if (wr_en && idx_is(widx, PPC_IDX_DATA)) begin
      data_q <= pwdata_i[7:0];
    end
  end

  // Only software writes reach this register, never an override
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dir_q <= PPC_RST_DIR;
    end else if (wr_en && idx_is(widx, PPC_IDX_DIR)) begin
      dir_q <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      drive_q <= PPC_RST_DRIVE;
    end else if (wr_en && idx_is(widx, PPC_IDX_DRIVE)) begin
      drive_q <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pull_q <= PPC_RST_PULL;
    end else if (wr_en && idx_is(widx, PPC_IDX_PULL)) begin
      pull_q <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pol_q <= PPC_RST_POL;
    end else if (wr_en && idx_is(widx, PPC_IDX_POL)) begin
      pol_q <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en_q <= PPC_RST_IRQ_EN;
    end else if (wr_en && idx_is(widx, PPC_IDX_IRQ_EN)) begin
      irq_en_q <= pwdata_i[7:0];
    end
  end

  // Pin synchroniser; only sync_q and prev_q are looked at by logic, never meta_q
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
      prev_q <= 8'h00;
    end else begin
      meta_q <= pin_in_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pin_sync_o = sync_q;

  // Per-pin direction arbitration and edge detection
  for (genvar i = 0; i < PPC_WIDTH; i++) begin : g_pin
    always_comb begin
      eff_oe[i] = dir_q[i];
      eff_out[i] = data_q[i];
      if (i == PPC_PIN_SHUTDOWN && periph_i.pwm_shutdown_en) begin
        // Shutdown wins over an enabled channel on this pin
        eff_oe[i] = 1'b0;
      end else if (periph_i.pwm_en[i]) begin
        eff_oe[i] = 1'b1;
        eff_out[i] = periph_i.pwm_out[i];
      end else if (PPC_TIMER_MASK[i] && periph_i.timer_oc_en[i]) begin
        eff_oe[i] = 1'b1;
        eff_out[i] = periph_i.timer_out[i];
      end else if (PPC_SCI_MASK[i] && periph_i.sci_en[i]) begin
        eff_oe[i] = periph_i.sci_oe[i];
        eff_out[i] = periph_i.sci_out[i];
      end
    end

    // Polarity 1 looks for a rising edge, 0 for a falling one
    assign edge_hit[i] = pol_q[i] ? (sync_q[i] & ~prev_q[i])
                                  : (~sync_q[i] & prev_q[i]);
  end

  // Pad controls are registered so pins never see decode glitches
  always_comb begin
    pad_d.out = eff_out;
    pad_d.oe = eff_oe;
    pad_d.reduced = drive_q & eff_oe;
    pad_d.pull_up = pull_q & ~eff_oe & ~pol_q;
    pad_d.pull_down = pull_q & ~eff_oe & pol_q;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad_d;
    end
  end

  assign pad_o = pad_q;

  // Flags: an edge in the same cycle as its clear keeps the flag set
  assign clr_req = (wr_en && idx_is(widx, PPC_IDX_IRQ_CLR)) ?
                   pwdata_i[7:0] : 8'h00;
  assign flag_d = (flag_q & ~clr_req) | edge_hit;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flag_q <= PPC_RST_FLAG;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign irq_o = |(flag_q & irq_en_q);

endmodule

/* ppc_sva.sv */
// Purpose: Concurrent checks on the bus ready and the pad controls of the pin block
// Assumes: Pad outputs lag their causes by one clock
// Notes: Sees the top module's ports only
`timescale 1ns/1ps
module ppc_sva (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Observed ports
  input wire logic pready_o,
  input wire ppc_pkg::ppc_periph_s periph_i,
  input wire ppc_pkg::ppc_pad_s pad_o
);
  import ppc_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  no_wait_a: assert property (pready_o)
    else $error("register bus stalled");
  drive_input_a: assert property ((pad_o.reduced & ~pad_o.oe) == 8'h00)
    else $error("reduced drive on input");
  pull_output_a: assert property
    (((pad_o.pull_up | pad_o.pull_down) & pad_o.oe) == 8'h00)
    else $error("pull on output");
  pull_dir_a: assert property ((pad_o.pull_up & pad_o.pull_down) == 8'h00)
    else $error("pull up and down together");
  pwm_force_a: assert property ((periph_i.pwm_en[6:3] != 4'h0) |=>
    ((~pad_o.oe[6:3] & $past(periph_i.pwm_en[6:3])) == 4'h0))
    else $error("pulse channel not output");
  shutdown_in_a: assert property (periph_i.pwm_shutdown_en |=> !pad_o.oe[7])
    else $error("shutdown pin not input");
  pwm_seven_a: assert property
    (periph_i.pwm_en[7] && !periph_i.pwm_shutdown_en |=>
    pad_o.oe[7] && pad_o.out[7] == $past(periph_i.pwm_out[7]))
    else $error("pin 7 pulse override wrong");
  timer_pin_a: assert property
    (!periph_i.pwm_en[1] && periph_i.timer_oc_en[1] |=>
    pad_o.oe[1] && pad_o.out[1] == $past(periph_i.timer_out[1]))
    else $error("pin 1 timer override wrong");
  serial_pin_a: assert property
    (!periph_i.pwm_en[0] && !periph_i.timer_oc_en[0] && periph_i.sci_en[0]
    |=> pad_o.oe[0] == $past(periph_i.sci_oe[0]))
    else $error("pin 0 serial direction wrong");
endmodule
bind ppc_top ppc_sva i_ppc_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .pready_o(pready_o), .periph_i(periph_i), .pad_o(pad_o));

/* ppc_pins.sv */
// Purpose: Pin wires seen from outside the block
// Assumes: The block's own drive wins over an external driver
// Notes: A floating pin shows the inverse of the external driver's level
`timescale 1ns/1ps
module ppc_pins (
  // Pad controls
  input wire ppc_pkg::ppc_pad_s pad_i,
  // External driver
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_i,
  // Pin levels
  output logic [7:0] pin_o
);
  import ppc_pkg::*;
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (pad_i.oe[b]) pin_o[b] = pad_i.out[b];
      else if (ext_en_i[b]) pin_o[b] = ext_i[b];
      else if (pad_i.pull_up[b]) pin_o[b] = 1'b1;
      else if (pad_i.pull_down[b]) pin_o[b] = 1'b0;
      else pin_o[b] = ~ext_i[b];
    end
  end
endmodule

/* ppc_bench.sv */
// Purpose: Self-checking bench for the pin control block
// Assumes: Zero-wait APB slave, pads one clock behind causes
// Notes: Byte address is the word index times four
`timescale 1ns/1ps
module ppc_top_bench;
  import ppc_pkg::*;
  logic clk_sys_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [PPC_AW-1:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic pready_o, pslverr_o, irq_o;
  logic [7:0] pin_in_i, pin_sync_o, ext_en, ext;
  ppc_periph_s per;
  ppc_pad_s pad_o;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  ppc_top i_ppc_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .periph_i(per),
    .pin_in_i(pin_in_i), .pad_o(pad_o), .pin_sync_o(pin_sync_o),
    .irq_o(irq_o));
  ppc_pins i_ppc_pins (.pad_i(pad_o), .ext_en_i(ext_en), .ext_i(ext),
    .pin_o(pin_in_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Run is about 120 cycles; the ceiling of 3000 leaves wide margin
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {idx, 2'h0};
    pwdata_i <= {24'h0, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rdat = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rdat, {24'h0, exp});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic drive(input ppc_periph_s p);
    @(posedge clk_sys_i);
    per <= p;
    settle(1);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++) rd(PPC_IDX_DIR + 10'(i), 8'h00);
    wr(PPC_IDX_DIR, 8'hA5);
    wr(PPC_IDX_DRIVE, 8'h3C);
    wr(PPC_IDX_PULL, 8'hFF);
    wr(PPC_IDX_POL, 8'h0F);
    rd(PPC_IDX_DIR, 8'hA5);
    rd(PPC_IDX_DRIVE, 8'h3C);
    settle(1);
    chk(pad_o.oe, 8'hA5);
    chk(pad_o.reduced, 8'h24);
    chk(pad_o.pull_down, 8'h0A);
    chk(pad_o.pull_up, 8'h50);
    apb(1'b0, 10'h3FF, 8'h00);
    chk(pslverr_o, 1'b1);
    chk(rdat, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_over;
    drive('{pwm_en:8'hF8, pwm_out:8'hD0, timer_oc_en:8'h02, timer_out:8'h02,
      sci_en:8'h01, default:'0});
    chk(pad_o.oe, 8'hFE);
    chk(pad_o.out, 8'hD2);
    chk(pad_o.reduced, 8'h3C);
    chk(pad_o.pull_down, 8'h01);
    rd(PPC_IDX_DIR, 8'hA5);
    drive('{pwm_en:8'hF8, pwm_shutdown_en:1'b1, default:'0});
    chk(pad_o.oe, 8'h7D);
    drive('0);
    $display("test override done");
  endtask
  task automatic t_irq;
    wr(PPC_IDX_DIR, 8'h00);
    settle(4);
    wr(PPC_IDX_IRQ_CLR, 8'hFF);
    wr(PPC_IDX_IRQ_EN, 8'h11);
    rd(PPC_IDX_IRQ_STAT, 8'h00);
    @(posedge clk_sys_i);
    ext <= 8'hFF;
    settle(4);
    chk(irq_o, 1'b1);
    chk(pin_sync_o, 8'hFF);
    rd(PPC_IDX_INPUT, 8'hFF);
    rd(PPC_IDX_IRQ_STAT, 8'h0F);
    @(posedge clk_sys_i);
    ext <= 8'h00;
    settle(4);
    rd(PPC_IDX_IRQ_STAT, 8'hFF);
    wr(PPC_IDX_IRQ_CLR, 8'h0F);
    rd(PPC_IDX_IRQ_STAT, 8'hF0);
    chk(irq_o, 1'b1);
    wr(PPC_IDX_IRQ_EN, 8'h01);
    settle(1);
    chk(irq_o, 1'b0);
    wr(PPC_IDX_DATA, 8'h3C);
    wr(PPC_IDX_DIR, 8'h0F);
    rd(PPC_IDX_DATA, 8'h0C);
    $display("test irq done");
  endtask
  initial begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = '0;
    pwdata_i = '0;
    per = '0;
    ext_en = 8'hFF;
    ext = 8'h00;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_regs();
    t_over();
    t_irq();
    report_and_stop();
  end
endmodule
